/* pkg/crg_consts.svh */
// Constants of the countdown reset guard: ports, indices, fields, timing
`ifndef CRG_CONSTS_SVH
`define CRG_CONSTS_SVH
// ==========================================================
// Host port addresses
`define CRG_PORT_INDEX   16'h002e
`define CRG_PORT_DATA    16'h002f
// ==========================================================
// Configuration keys and guard logical device number
`define CRG_KEY_UNLOCK   8'h87
`define CRG_KEY_LOCK     8'haa
`define CRG_GUARD_LDN    8'h07
// ==========================================================
// Register indices
`define CRG_IDX_LDN      8'h07
`define CRG_IDX_ENABLE   8'h30
`define CRG_IDX_ACTIVATE 8'hf0
`define CRG_IDX_TBASE    8'hf5
`define CRG_IDX_COUNT    8'hf6
// ==========================================================
// Field positions
`define CRG_ENABLE_BIT   0
`define CRG_ACTIVATE_BIT 7
`define CRG_MINUTE_BIT   3
// ==========================================================
// Reset value and read value while locked
`define CRG_RST_BYTE     8'h00
`define CRG_RD_LOCKED    8'hff
// ==========================================================
// Timing
`define CRG_CLK_PERIOD_NS 5
`define CRG_SECOND_NS     1000000000
`define CRG_SEC_PER_MIN   60
`define CRG_SECOND_CYC    (`CRG_SECOND_NS / `CRG_CLK_PERIOD_NS)
`endif

/* pkg/crg_pkg.sv */
// Types of the countdown reset guard
package crg_pkg;
  // ==========================================================
  // Configuration lock states, Gray along the unlock path
  typedef enum logic [1:0] {
    CRG_LK_CLOSED = 2'h0,
    CRG_LK_HALF   = 2'h1,
    CRG_LK_OPEN   = 2'h3
  } crg_lock_e;
  typedef logic [7:0] crg_byte_t;
endpackage : crg_pkg

/* pkg/crg_tick_if.sv */
// Interface between the guard core and its time-base generator
`timescale 1ns/10ps
interface crg_tick_if;
  logic run;     // Countdown running
  logic minute;  // Minute time base selected
  logic restart; // Restart the prescaler
  logic tick;    // One time-base unit elapsed
  modport core (output run, output minute, output restart, input tick);
  modport gen  (input run, input minute, input restart, output tick);
endinterface : crg_tick_if

/* hw/crg_tick.sv */
// Time-base generator: one tick per second or per minute
`timescale 1ns/10ps
`include "crg_consts.svh"
module crg_tick #(
  parameter int unsigned SEC_CYCLES  = `CRG_SECOND_CYC,
  parameter int unsigned SEC_PER_MIN = `CRG_SEC_PER_MIN
) (
  input  wire logic clock_i, // System clock
  input  wire logic rst_i,   // Asynchronous reset
  crg_tick_if.gen   tb       // Generator side of the tick bus
);
  // ==========================================================
  // Prescaler state
  logic [31:0] cyc_reg, cyc_next;
  logic [7:0]  sec_reg, sec_next;
  logic        tick_reg, tick_next;
  logic        sec_end;

  // Next values of the prescaler
  always_comb begin
    cyc_next  = cyc_reg;
    sec_next  = sec_reg;
    tick_next = 1'b0;
    sec_end   = (cyc_reg == SEC_CYCLES - 1);
    if (tb.restart || !tb.run) begin
      cyc_next = '0;
      sec_next = '0;
    end else if (sec_end) begin
      cyc_next = '0;
      // Minute base counts whole seconds
      if (!tb.minute || sec_reg == 8'(SEC_PER_MIN - 1)) begin
        sec_next  = '0;
        tick_next = 1'b1;
      end else begin
        sec_next = sec_reg + 8'h01;
      end
    end else begin
      cyc_next = cyc_reg + 32'h1;
    end
  end

  // Prescaler registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_reg  <= '0;
      sec_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cyc_reg  <= cyc_next;
      sec_reg  <= sec_next;
      tick_reg <= tick_next;
    end
  end

  assign tb.tick = tick_reg;

  // ==========================================================
  // Checks
  // Minute ticks come only after the last second of a minute
  AST_MINUTE: assert property (@(posedge clock_i) disable iff (rst_i)
    tb.tick && $past(tb.minute) |-> $past(sec_reg) == 8'(SEC_PER_MIN - 1))
    else $error("minute tick before a full minute");
endmodule : crg_tick

/* hw/crg_guard.sv */
// Countdown reset guard with index/data configuration port
// Behaviour
// - Count down per unit, reset at zero
// - Countdown lengths from 1 to 255 units
// - Two 87 writes to index unlock
// - Select logical device 07 via index 07
// - Index 30 value 01 enables device
// - Index F0 value 80 activates guard
// - Index F6 holds count, zero disables
// - Index F5: 71h seconds, 79h minutes
// - Max count, seconds: reset after 255 s
`timescale 1ns/10ps
`include "crg_consts.svh"
module crg_guard #(
  parameter int unsigned SEC_CYCLES  = `CRG_SECOND_CYC,
  parameter int unsigned SEC_PER_MIN = `CRG_SEC_PER_MIN
) (
  input  wire logic        clock_i,     // System clock, 200 MHz
  input  wire logic        rst_i,       // Asynchronous reset
  input  wire logic [15:0] io_addr_i,   // Host I/O address
  input  wire logic        io_wr_i,     // Host write strobe
  input  wire logic        io_rd_i,     // Host read strobe
  input  wire logic [7:0]  io_wdata_i,  // Host write data
  output logic      [7:0]  io_rdata_o,  // Read data, one cycle later
  output logic             cfg_open_o,  // Configuration unlocked
  output logic             running_o,   // Countdown running
  output logic             sys_reset_o  // System reset request
);
  // ==========================================================
  // Port decode
  logic idx_wr, dat_wr, idx_rd, dat_rd, open;
  assign idx_wr = io_wr_i && (io_addr_i == `CRG_PORT_INDEX);
  assign dat_wr = io_wr_i && (io_addr_i == `CRG_PORT_DATA);
  assign idx_rd = io_rd_i && (io_addr_i == `CRG_PORT_INDEX);
  assign dat_rd = io_rd_i && (io_addr_i == `CRG_PORT_DATA);

  // ==========================================================
  // Lock sequence
  crg_pkg::crg_lock_e lock_reg, lock_next;

  // Two unlock keys in a row open the port
  always_comb begin
    lock_next = lock_reg;
    if (idx_wr) begin
      unique case (lock_reg)
        crg_pkg::CRG_LK_CLOSED: begin
          if (io_wdata_i == `CRG_KEY_UNLOCK) lock_next = crg_pkg::CRG_LK_HALF;
        end
        crg_pkg::CRG_LK_HALF: begin
          if (io_wdata_i == `CRG_KEY_UNLOCK) lock_next = crg_pkg::CRG_LK_OPEN;
          else lock_next = crg_pkg::CRG_LK_CLOSED;
        end
        crg_pkg::CRG_LK_OPEN: begin
          if (io_wdata_i == `CRG_KEY_LOCK) lock_next = crg_pkg::CRG_LK_CLOSED;
        end
        default: lock_next = crg_pkg::CRG_LK_CLOSED;
      endcase
    end
  end

  // Lock register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lock_reg <= crg_pkg::CRG_LK_CLOSED;
    end else begin
      lock_reg <= lock_next;
    end
  end

  assign open = (lock_reg == crg_pkg::CRG_LK_OPEN);

  // ==========================================================
  // Configuration registers
  crg_pkg::crg_byte_t index_reg, index_next;
  crg_pkg::crg_byte_t ldn_reg, ldn_next;
  crg_pkg::crg_byte_t enable_reg, enable_next;
  crg_pkg::crg_byte_t activate_reg, activate_next;
  crg_pkg::crg_byte_t tbase_reg, tbase_next;
  crg_pkg::crg_byte_t limit_reg, limit_next;
  logic cfg_wr, guard_sel, load_wr, dis_wr;

  assign cfg_wr    = open && dat_wr;
  assign guard_sel = (ldn_reg == `CRG_GUARD_LDN);
  assign load_wr   = cfg_wr && guard_sel && (index_reg == `CRG_IDX_COUNT);
  assign dis_wr    = cfg_wr && guard_sel &&
                     ((index_reg == `CRG_IDX_ENABLE) || (index_reg == `CRG_IDX_ACTIVATE));

  // Index first, then data at the selected index
  always_comb begin
    index_next    = index_reg;
    ldn_next      = ldn_reg;
    enable_next   = enable_reg;
    activate_next = activate_reg;
    tbase_next    = tbase_reg;
    limit_next    = limit_reg;
    if (open && idx_wr) index_next = io_wdata_i;
    if (cfg_wr) begin
      if (index_reg == `CRG_IDX_LDN) ldn_next = io_wdata_i;
      if (guard_sel) begin
        unique case (index_reg)
          `CRG_IDX_ENABLE:   enable_next   = io_wdata_i;
          `CRG_IDX_ACTIVATE: activate_next = io_wdata_i;
          `CRG_IDX_TBASE:    tbase_next    = io_wdata_i;
          `CRG_IDX_COUNT:    limit_next    = io_wdata_i;
          default: ;
        endcase
      end
    end
  end

  // Configuration register bank
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      index_reg    <= `CRG_RST_BYTE;
      ldn_reg      <= `CRG_RST_BYTE;
      enable_reg   <= `CRG_RST_BYTE;
      activate_reg <= `CRG_RST_BYTE;
      tbase_reg    <= `CRG_RST_BYTE;
      limit_reg    <= `CRG_RST_BYTE;
    end else begin
      index_reg    <= index_next;
      ldn_reg      <= ldn_next;
      enable_reg   <= enable_next;
      activate_reg <= activate_next;
      tbase_reg    <= tbase_next;
      limit_reg    <= limit_next;
    end
  end

  // ==========================================================
  // Countdown
  crg_pkg::crg_byte_t count_reg, count_next;
  logic               expired_reg, expired_next;
  logic               armed, running, fire;
  crg_tick_if         tick_bus ();

  assign armed   = enable_reg[`CRG_ENABLE_BIT] && activate_reg[`CRG_ACTIVATE_BIT];
  assign running = armed && (count_reg != 8'h00);
  assign fire    = running && tick_bus.tick && (count_reg == 8'h01);

  // Load, decrement and expiry; a new expiry beats a clear
  always_comb begin
    count_next   = count_reg;
    expired_next = expired_reg;
    if (load_wr) begin
      count_next   = io_wdata_i;
      expired_next = 1'b0;
    end else if (running && tick_bus.tick) begin
      count_next = count_reg - 8'h01;
    end
    if (dis_wr) expired_next = 1'b0;
    if (fire) expired_next = 1'b1;
  end

  // Countdown registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg   <= `CRG_RST_BYTE;
      expired_reg <= 1'b0;
    end else begin
      count_reg   <= count_next;
      expired_reg <= expired_next;
    end
  end

  // Time base follows the count
  assign tick_bus.run     = running;
  assign tick_bus.minute  = tbase_reg[`CRG_MINUTE_BIT];
  assign tick_bus.restart = load_wr;

  crg_tick #(
    .SEC_CYCLES  (SEC_CYCLES),
    .SEC_PER_MIN (SEC_PER_MIN)
  ) u_tick (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tb      (tick_bus)
  );

  // ==========================================================
  // Read path
  crg_pkg::crg_byte_t rdata_reg, rdata_next;

  // Registered read mux; live count at the count index
  always_comb begin
    rdata_next = rdata_reg;
    if (io_rd_i) rdata_next = `CRG_RD_LOCKED;
    if (open && idx_rd) rdata_next = index_reg;
    if (open && dat_rd) begin
      rdata_next = 8'h00;
      if (index_reg == `CRG_IDX_LDN) rdata_next = ldn_reg;
      else if (guard_sel) begin
        unique case (index_reg)
          `CRG_IDX_ENABLE:   rdata_next = enable_reg;
          `CRG_IDX_ACTIVATE: rdata_next = activate_reg;
          `CRG_IDX_TBASE:    rdata_next = tbase_reg;
          `CRG_IDX_COUNT:    rdata_next = count_reg;
          default:           rdata_next = 8'h00;
        endcase
      end
    end
  end

  // Read data register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= `CRG_RST_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs
  assign io_rdata_o  = rdata_reg;
  assign cfg_open_o  = open;
  assign running_o   = running;
  assign sys_reset_o = expired_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_first_key;
    idx_wr && io_wdata_i == `CRG_KEY_UNLOCK && lock_reg == crg_pkg::CRG_LK_CLOSED;
  endsequence
  sequence s_second_key;
    idx_wr && io_wdata_i == `CRG_KEY_UNLOCK && lock_reg == crg_pkg::CRG_LK_HALF;
  endsequence
  sequence s_last_unit;
    running && tick_bus.tick && count_reg == 8'h01 && !load_wr;
  endsequence

  AST_HALF: assert property (s_first_key |=> lock_reg == crg_pkg::CRG_LK_HALF)
    else $error("first key not taken");
  AST_UNLOCK: assert property (s_second_key |=> open)
    else $error("unlock sequence did not open port");
  AST_LOCKED_IGNORE: assert property (!open && dat_wr |=> $stable(enable_reg) &&
    $stable(limit_reg) && $stable(ldn_reg))
    else $error("write accepted while locked");
  AST_LDN_SEL: assert property (cfg_wr && index_reg == `CRG_IDX_LDN |=>
    ldn_reg == $past(io_wdata_i))
    else $error("device select not stored");
  AST_INDEX: assert property (open && idx_wr && io_wdata_i != `CRG_KEY_LOCK |=>
    index_reg == $past(io_wdata_i))
    else $error("index not stored");
  AST_ENABLE: assert property (!enable_reg[`CRG_ENABLE_BIT] && !load_wr |=>
    $stable(count_reg))
    else $error("count moved while disabled");
  AST_ACTIVATE: assert property (!activate_reg[`CRG_ACTIVATE_BIT] && !load_wr |=>
    $stable(count_reg))
    else $error("count moved while inactive");
  AST_ZERO_OFF: assert property (load_wr && io_wdata_i == 8'h00 |=> !running ##1 !running)
    else $error("zero count did not disable");
  AST_DECR: assert property (running && tick_bus.tick && count_reg > 8'h01 && !load_wr |=>
    count_reg == $past(count_reg) - 8'h01 && !sys_reset_o)
    else $error("count did not step down");
  AST_EXPIRE: assert property (s_last_unit |=> sys_reset_o && count_reg == 8'h00)
    else $error("no reset at zero");
endmodule : crg_guard

/* bench/crg_host.sv */
// Host software model driving the index/data configuration port
`timescale 1ns/10ps
`include "crg_consts.svh"
module crg_host (
  input  wire logic        clock_i, // System clock
  input  wire logic [7:0]  rdata_i, // Read data from the guard
  output logic      [15:0] addr_o,  // I/O address
  output logic             wr_o,    // Write strobe
  output logic             rd_o,    // Read strobe
  output logic      [7:0]  wdata_o  // Write data
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    addr_o  = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end
  // ==========================================================
  // Bus cycles, launched and ended on falling edges
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clock_i);
    wr_o    = 1'b0;
    wdata_o = ~d; // Stale data never left on the bus
  endtask : io_wr
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clock_i);
    rd_o   = 1'b0;
    d      = rdata_i;
  endtask : io_rd
  // Index write, then data access
  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] v);
    io_wr(`CRG_PORT_INDEX, i);
    io_wr(`CRG_PORT_DATA, v);
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] i, output logic [7:0] v);
    io_wr(`CRG_PORT_INDEX, i);
    io_rd(`CRG_PORT_DATA, v);
  endtask : cfg_rd
  // Unlock and select the guard device
  task automatic open_guard();
    io_wr(`CRG_PORT_INDEX, `CRG_KEY_UNLOCK);
    io_wr(`CRG_PORT_INDEX, `CRG_KEY_UNLOCK);
    cfg_wr(`CRG_IDX_LDN, `CRG_GUARD_LDN);
  endtask : open_guard
endmodule : crg_host

/* bench/crg_guard_tb.sv */
// Self-checking bench of the countdown reset guard
`timescale 1ns/10ps
`include "crg_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module crg_guard_tb;
  localparam int unsigned SEC = 4;
  localparam int unsigned SPM = 3;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic [15:0] addr;
  logic        wr, rd, cfg_open, running, sys_reset;
  logic [7:0]  wdata, rdata, v;
  logic [31:0] seed = 32'he39e;
  logic [7:0]  idxs [5] = '{8'h07, 8'h30, 8'hf0, 8'hf5, 8'hf6};
  int          model [int]; // Expected register contents
  int          n_fail = 0;
  int          compares = 0;
  int          got;
  // ==========================================================
  // Clock and instances
  always #2.5 clock_i = ~clock_i;
  crg_guard #(.SEC_CYCLES(SEC), .SEC_PER_MIN(SPM)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd),
    .io_wdata_i(wdata), .io_rdata_o(rdata), .cfg_open_o(cfg_open),
    .running_o(running), .sys_reset_o(sys_reset));
  crg_host host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic put(input logic [7:0] i, input logic [7:0] d);
    host.cfg_wr(i, d);
    model[i] = d;
  endtask : put
  task automatic chk_reg(input logic [7:0] i);
    host.cfg_rd(i, v);
    `CHK(v, 8'(model[i]))
  endtask : chk_reg
  // Load a count and measure the cycles until the reset request
  task automatic expire(input int n, input int unit);
    put(`CRG_IDX_COUNT, 8'(n));
    `CHK(running, 1'b1)
    got = 0;
    while (sys_reset !== 1'b1 && got < 2000) begin
      @(negedge clock_i);
      got++;
    end
    `CHK(got >= n * unit && got <= n * unit + 3, 1'b1)
    model[`CRG_IDX_COUNT] = 0;
  endtask : expire
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // ==========================================================
  // Watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    `CHK({cfg_open, running, sys_reset}, 3'b000)
    host.cfg_rd(`CRG_IDX_COUNT, v);
    `CHK(v, `CRG_RD_LOCKED)
    host.cfg_wr(`CRG_IDX_ENABLE, 8'h01);
    host.io_wr(`CRG_PORT_INDEX, `CRG_KEY_UNLOCK);
    host.io_wr(`CRG_PORT_INDEX, 8'h07);
    host.io_wr(`CRG_PORT_INDEX, `CRG_KEY_UNLOCK);
    `CHK(cfg_open, 1'b0)
    host.io_wr(`CRG_PORT_INDEX, 8'h00);
    host.open_guard();
    `CHK(cfg_open, 1'b1)
    foreach (idxs[k]) model[idxs[k]] = 0;
    model[`CRG_IDX_LDN] = 7;
    foreach (idxs[k]) chk_reg(idxs[k]);
    // Enable, activate, seconds base; zero count stays idle
    put(`CRG_IDX_TBASE, 8'h71);
    chk_reg(`CRG_IDX_TBASE);
    put(`CRG_IDX_ENABLE, 8'h01);
    chk_reg(`CRG_IDX_ENABLE);
    put(`CRG_IDX_ACTIVATE, 8'h80);
    chk_reg(`CRG_IDX_ACTIVATE);
    repeat (100) @(negedge clock_i);
    `CHK({running, sys_reset}, 2'b00)
    // Shortest count, sticky request, clear by count write
    expire(1, SEC);
    repeat (10) @(negedge clock_i);
    `CHK(sys_reset, 1'b1)
    chk_reg(`CRG_IDX_COUNT);
    put(`CRG_IDX_COUNT, 8'h00);
    `CHK({running, sys_reset}, 2'b00)
    // Timely reloads, count longer than each interval
    repeat (6) begin
      put(`CRG_IDX_COUNT, 8'h04);
      repeat (8) @(negedge clock_i);
    end
    `CHK(sys_reset, 1'b0)
    // Random counts, then minute base and the maximum count
    repeat (3) begin
      seed = lfsr(seed);
      expire(int'(seed[3:0]) + 1, SEC);
    end
    put(`CRG_IDX_TBASE, 8'h79);
    expire(2, SEC * SPM);
    put(`CRG_IDX_TBASE, 8'h71);
    expire(255, SEC);
    put(`CRG_IDX_COUNT, 8'h00);
    // Other logical device hides the guard
    host.cfg_wr(`CRG_IDX_LDN, 8'h01);
    host.cfg_wr(`CRG_IDX_COUNT, 8'h09);
    `CHK(running, 1'b0)
    host.cfg_wr(`CRG_IDX_LDN, `CRG_GUARD_LDN);
    chk_reg(`CRG_IDX_COUNT);
    host.io_wr(`CRG_PORT_INDEX, `CRG_KEY_LOCK);
    `CHK(cfg_open, 1'b0)
    close_out();
  end
endmodule : crg_guard_tb
